// *** core/hmwu_mailbox.sv ***
`timescale 1ns/1ps
`include "hmwu_regs.svh"

module hmwu_mailbox (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic wr,
   input wire logic [7:0] wdata,
   output logic [7:0] value,
   output logic event_pulse
);
   logic [7:0] next_value;

   always_comb begin
      next_value = value;
      if (wr) begin
         next_value = wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         value <= `HMWU_BYTE_RST;
         event_pulse <= 1'b0;
      end else begin
         value <= next_value;
         event_pulse <= wr;
      end
   end

   a_mbox_event: assert property (@(posedge clk_sys) disable iff (!nrst)
      wr |=> event_pulse && value == $past(wdata))
      else $error("mailbox write did not store and signal");
endmodule

// *** core/hmwu_pkg.sv ***
package hmwu_pkg;

   typedef enum logic {hmwu_idle, hmwu_wait} hmwu_state_type;

   // byte order matches the ec offsets: base at bytes 0-3
   typedef struct packed {
      logic [15:0] wr_limit;
      logic [15:0] rd_limit;
      logic [31:0] base;
   } hmwu_region_type;

   typedef struct packed {
      logic req;
      logic we;
      logic [31:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } hmwu_mem_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [3:0] addr;
      logic [7:0] wdata;
   } hmwu_host_req_type;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] addr;
      logic [7:0] wdata;
   } hmwu_ec_req_type;

endpackage

// *** core/hmwu_region_check.sv ***
`timescale 1ns/1ps

module hmwu_region_check (
   input wire hmwu_pkg::hmwu_region_type cfg,
   input wire logic [14:0] win_addr,
   output logic [31:0] phys,
   output logic can_read,
   output logic can_write
);
   logic [31:0] rd_end;
   logic [31:0] wr_end;

   // limits compare against base plus limit, so either may exceed the other
   always_comb begin
      phys = {cfg.base[31:2], 2'h0} + {17'h0_0000, win_addr};
      rd_end = {cfg.base[31:2], 2'h0} + {16'h0000, cfg.rd_limit};
      wr_end = {cfg.base[31:2], 2'h0} + {16'h0000, cfg.wr_limit};
      can_read = phys < rd_end;
      can_write = phys < wr_end;
   end
endmodule

// *** core/hmwu_regs.svh ***
`ifndef HMWU_REGS_SVH
`define HMWU_REGS_SVH

// ----------------------------------------
// host byte offsets
// ----------------------------------------
`define HMWU_H_H2E 4'h0
`define HMWU_H_E2H 4'h1
`define HMWU_H_ADDR_L 4'h2
`define HMWU_H_ADDR_H 4'h3
`define HMWU_H_DATA0 4'h4
`define HMWU_H_DATA3 4'h7
`define HMWU_H_SRC_L 4'h8
`define HMWU_H_SRC_H 4'h9
`define HMWU_H_EN_L 4'hA
`define HMWU_H_EN_H 4'hB
`define HMWU_H_APPID 4'hC

// ----------------------------------------
// ec byte offsets
// ----------------------------------------
`define HMWU_E_REGION_END 5'h0F
`define HMWU_E_H2E 5'h10
`define HMWU_E_E2H 5'h11
`define HMWU_E_SET_L 5'h12
`define HMWU_E_SET_H 5'h13
`define HMWU_E_SRC_L 5'h14
`define HMWU_E_SRC_H 5'h15

// ----------------------------------------
// fields and reset values
// ----------------------------------------
`define HMWU_ACC_8 2'h0
`define HMWU_ACC_16 2'h1
`define HMWU_ACC_AUTO 2'h3
`define HMWU_REGION_SEL_BIT 7
`define HMWU_BYTE_RST 8'h00
`define HMWU_EN_RST 16'h0001
`define HMWU_REGION_LIMIT_RST 16'h0000

`endif

// *** core/hmwu_top.sv ***
`timescale 1ns/1ps
`include "hmwu_regs.svh"


module hmwu_top (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire hmwu_pkg::hmwu_host_req_type host_req,
   output logic [7:0] host_rdata,
   output logic host_rvalid,
   output logic host_busy,
   input wire hmwu_pkg::hmwu_ec_req_type ec_req,
   output logic [7:0] ec_rdata,
   output logic ec_rvalid,
   output hmwu_pkg::hmwu_mem_type mem_out,
   input wire logic mem_ack,
   input wire logic [31:0] mem_rdata,
   output logic host_event,
   output logic e2h_irq,
   output logic ec_h2e_irq
);
   // ----------------------------------------
   // state
   // ----------------------------------------
   hmwu_pkg::hmwu_state_type state, next_state;
   hmwu_pkg::hmwu_region_type region [2];
   hmwu_pkg::hmwu_region_type next_region [2];
   hmwu_pkg::hmwu_mem_type next_mem_out;
   logic [7:0] addr_lsb, next_addr_lsb;
   logic [7:0] addr_msb, next_addr_msb;
   logic [31:0] window_data, next_window_data;
   logic [15:0] software_event_bits, next_software_event_bits;
   logic [15:0] software_event_enables, next_software_event_enables;
   logic [7:0] app_id, next_app_id;
   logic [1:0] pend_byte, next_pend_byte;
   logic [3:0] pend_lanes, next_pend_lanes;
   logic [7:0] next_host_rdata, next_ec_rdata;
   logic next_host_rvalid, next_ec_rvalid, next_host_busy;
   logic next_host_event, next_e2h_irq;

   logic [7:0] h2e_value, e2h_value;
   logic e2h_pulse;
   logic h2e_wr, e2h_wr;
   logic [1:0] access_type;
   logic [1:0] hb;
   logic [12:0] window_dword;
   logic [14:0] window_address;
   logic region_sel;
   logic [31:0] phys [2];
   logic rd_ok [2];
   logic wr_ok [2];
   logic cur_rd, cur_wr;
   logic is_data;
   logic [3:0] rl, wl;
   logic [15:0] set_bits, clr_bits;
   logic [7:0] host_view;

   // ----------------------------------------
   // window address and regions
   // ----------------------------------------
   assign access_type = addr_lsb[1:0];
   assign window_dword = {addr_msb[6:0], addr_lsb[7:2]};
   assign window_address = {window_dword, 2'h0};
   assign region_sel = addr_msb[`HMWU_REGION_SEL_BIT];
   assign hb = host_req.addr[1:0];
   assign is_data = host_req.addr >= `HMWU_H_DATA0 && host_req.addr <= `HMWU_H_DATA3;
   assign cur_rd = rd_ok[region_sel];
   assign cur_wr = wr_ok[region_sel];

   for (genvar g = 0; g < 2; g++) begin : g_region
      hmwu_region_check u_check (
         .cfg(region[g]),
         .win_addr(window_address),
         .phys(phys[g]),
         .can_read(rd_ok[g]),
         .can_write(wr_ok[g])
      );
   end

   // ----------------------------------------
   // mailboxes
   // ----------------------------------------
   assign h2e_wr = host_req.wr && state == hmwu_pkg::hmwu_idle && host_req.addr == `HMWU_H_H2E;
   assign e2h_wr = ec_req.wr && ec_req.addr == `HMWU_E_E2H;

   hmwu_mailbox u_h2e (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .wr(h2e_wr),
      .wdata(host_req.wdata),
      .value(h2e_value),
      .event_pulse(ec_h2e_irq)
   );

   hmwu_mailbox u_e2h (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .wr(e2h_wr),
      .wdata(ec_req.wdata),
      .value(e2h_value),
      .event_pulse(e2h_pulse)
   );

   // ----------------------------------------
   // lane selection per transfer size
   // ----------------------------------------
   function automatic logic [3:0] read_lanes(input logic [1:0] t, input logic [1:0] b);
      if (t == `HMWU_ACC_8) begin
         return 4'h1 << b;
      end else if (t == `HMWU_ACC_16) begin
         return (b == 2'h0) ? 4'h3 : ((b == 2'h2) ? 4'hC : 4'h0);
      end
      return (b == 2'h0) ? 4'hF : 4'h0;
   endfunction

   function automatic logic [3:0] write_lanes(input logic [1:0] t, input logic [1:0] b);
      if (t == `HMWU_ACC_8) begin
         return 4'h1 << b;
      end else if (t == `HMWU_ACC_16) begin
         return (b == 2'h1) ? 4'h3 : ((b == 2'h3) ? 4'hC : 4'h0);
      end
      return (b == 2'h3) ? 4'hF : 4'h0;
   endfunction

   // ----------------------------------------
   // next state
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_region = region;
      next_mem_out = mem_out;
      next_addr_lsb = addr_lsb;
      next_addr_msb = addr_msb;
      next_window_data = window_data;
      next_software_event_enables = software_event_enables;
      next_app_id = app_id;
      next_pend_byte = pend_byte;
      next_pend_lanes = pend_lanes;
      next_host_rdata = host_rdata;
      next_host_rvalid = 1'b0;
      next_ec_rdata = ec_rdata;
      next_ec_rvalid = 1'b0;
      set_bits = {15'h0000, e2h_pulse};
      clr_bits = 16'h0000;
      rl = read_lanes(access_type, hb);
      wl = write_lanes(access_type, hb);

      if (host_req.addr == `HMWU_H_H2E) begin
         host_view = h2e_value;
      end else if (host_req.addr == `HMWU_H_E2H) begin
         host_view = e2h_value;
      end else if (host_req.addr == `HMWU_H_ADDR_L) begin
         host_view = addr_lsb;
      end else if (host_req.addr == `HMWU_H_ADDR_H) begin
         host_view = addr_msb;
      end else if (is_data) begin
         host_view = window_data[8 * hb +: 8];
      end else if (host_req.addr == `HMWU_H_SRC_L) begin
         host_view = software_event_bits[7:0];
      end else if (host_req.addr == `HMWU_H_SRC_H) begin
         host_view = software_event_bits[15:8];
      end else if (host_req.addr == `HMWU_H_EN_L) begin
         host_view = software_event_enables[7:0];
      end else if (host_req.addr == `HMWU_H_EN_H) begin
         host_view = software_event_enables[15:8];
      end else if (host_req.addr == `HMWU_H_APPID) begin
         host_view = app_id;
      end else begin
         host_view = 8'h00;
      end

      case (state)
         hmwu_pkg::hmwu_idle: begin
            if (host_req.wr) begin
               if (host_req.addr == `HMWU_H_ADDR_L) begin
                  next_addr_lsb = host_req.wdata;
               end else if (host_req.addr == `HMWU_H_ADDR_H) begin
                  next_addr_msb = host_req.wdata;
               end else if (is_data) begin
                  next_window_data[8 * hb +: 8] = host_req.wdata;
                  if (wl != 4'h0 && cur_wr) begin
                     next_mem_out = '{req: 1'b1, we: 1'b1, addr: phys[region_sel],
                                      be: wl, wdata: next_window_data};
                     next_state = hmwu_pkg::hmwu_wait;
                  end
                  if (access_type == `HMWU_ACC_AUTO && hb == 2'h3 && cur_wr) begin
                     {next_addr_msb[6:0], next_addr_lsb[7:2]} = window_dword + 13'h0001;
                  end
               end else if (host_req.addr == `HMWU_H_SRC_L) begin
                  clr_bits[7:0] = host_req.wdata;
               end else if (host_req.addr == `HMWU_H_SRC_H) begin
                  clr_bits[15:8] = host_req.wdata;
               end else if (host_req.addr == `HMWU_H_EN_L) begin
                  next_software_event_enables[7:0] = host_req.wdata;
               end else if (host_req.addr == `HMWU_H_EN_H) begin
                  next_software_event_enables[15:8] = host_req.wdata;
               end else if (host_req.addr == `HMWU_H_APPID) begin
                  next_app_id = host_req.wdata;
               end
            end else if (host_req.rd) begin
               if (is_data && rl != 4'h0 && cur_rd) begin
                  next_mem_out = '{req: 1'b1, we: 1'b0, addr: phys[region_sel],
                                   be: rl, wdata: window_data};
                  next_pend_byte = hb;
                  next_pend_lanes = rl;
                  next_state = hmwu_pkg::hmwu_wait;
               end else begin
                  next_host_rdata = host_view;
                  next_host_rvalid = 1'b1;
               end
               if (is_data && access_type == `HMWU_ACC_AUTO && hb == 2'h3) begin
                  {next_addr_msb[6:0], next_addr_lsb[7:2]} = window_dword + 13'h0001;
               end
            end
         end
         hmwu_pkg::hmwu_wait: begin
            if (mem_ack) begin
               next_mem_out.req = 1'b0;
               next_state = hmwu_pkg::hmwu_idle;
               if (!mem_out.we) begin
                  for (int i = 0; i < 4; i++) begin
                     if (pend_lanes[i]) begin
                        next_window_data[8 * i +: 8] = mem_rdata[8 * i +: 8];
                     end
                  end
                  next_host_rdata = next_window_data[8 * pend_byte +: 8];
                  next_host_rvalid = 1'b1;
               end
            end
         end
         default: begin
            next_state = hmwu_pkg::hmwu_idle;
         end
      endcase

      // ec side: region setup is out of the host's reach
      if (ec_req.wr) begin
         if (ec_req.addr <= `HMWU_E_REGION_END) begin
            next_region[ec_req.addr[3]][8 * ec_req.addr[2:0] +: 8] = ec_req.wdata;
         end else if (ec_req.addr == `HMWU_E_SET_L) begin
            set_bits[7:1] = ec_req.wdata[7:1];
         end else if (ec_req.addr == `HMWU_E_SET_H) begin
            set_bits[15:8] = ec_req.wdata;
         end
      end
      if (ec_req.rd) begin
         next_ec_rvalid = 1'b1;
         if (ec_req.addr <= `HMWU_E_REGION_END) begin
            next_ec_rdata = region[ec_req.addr[3]][8 * ec_req.addr[2:0] +: 8];
         end else if (ec_req.addr == `HMWU_E_H2E) begin
            next_ec_rdata = h2e_value;
         end else if (ec_req.addr == `HMWU_E_E2H) begin
            next_ec_rdata = e2h_value;
         end else if (ec_req.addr == `HMWU_E_SRC_L) begin
            next_ec_rdata = software_event_bits[7:0];
         end else if (ec_req.addr == `HMWU_E_SRC_H) begin
            next_ec_rdata = software_event_bits[15:8];
         end else begin
            next_ec_rdata = 8'h00;
         end
      end

      // a new event in the clearing cycle survives the clear
      next_software_event_bits = (software_event_bits & ~clr_bits) | set_bits;
      next_e2h_irq = next_software_event_bits[0];
      next_host_event = |(software_event_bits & software_event_enables);
      next_host_busy = next_state != hmwu_pkg::hmwu_idle;
   end

   // ----------------------------------------
   // registers
   // ----------------------------------------
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         state <= hmwu_pkg::hmwu_idle;
         for (int i = 0; i < 2; i++) begin
            region[i] <= '{wr_limit: `HMWU_REGION_LIMIT_RST, rd_limit: `HMWU_REGION_LIMIT_RST,
                           base: 32'h0000_0000};
         end
         mem_out <= '0;
         addr_lsb <= `HMWU_BYTE_RST;
         addr_msb <= `HMWU_BYTE_RST;
         window_data <= 32'h0000_0000;
         software_event_bits <= 16'h0000;
         software_event_enables <= `HMWU_EN_RST;
         app_id <= `HMWU_BYTE_RST;
         pend_byte <= 2'h0;
         pend_lanes <= 4'h0;
         host_rdata <= `HMWU_BYTE_RST;
         host_rvalid <= 1'b0;
         host_busy <= 1'b0;
         ec_rdata <= `HMWU_BYTE_RST;
         ec_rvalid <= 1'b0;
         host_event <= 1'b0;
         e2h_irq <= 1'b0;
      end else begin
         state <= next_state;
         region <= next_region;
         mem_out <= next_mem_out;
         addr_lsb <= next_addr_lsb;
         addr_msb <= next_addr_msb;
         window_data <= next_window_data;
         software_event_bits <= next_software_event_bits;
         software_event_enables <= next_software_event_enables;
         app_id <= next_app_id;
         pend_byte <= next_pend_byte;
         pend_lanes <= next_pend_lanes;
         host_rdata <= next_host_rdata;
         host_rvalid <= next_host_rvalid;
         host_busy <= next_host_busy;
         ec_rdata <= next_ec_rdata;
         ec_rvalid <= next_ec_rvalid;
         host_event <= next_host_event;
         e2h_irq <= next_e2h_irq;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);

   sequence s_idle_data_rd;
      state == hmwu_pkg::hmwu_idle && host_req.rd && !host_req.wr && is_data;
   endsequence

   sequence s_idle_data_wr;
      state == hmwu_pkg::hmwu_idle && host_req.wr && is_data;
   endsequence

   a_host_event_cause: assert property (
      |(software_event_bits & software_event_enables) |=> host_event)
      else $error("enabled event did not raise host event");

   a_e2h_raise: assert property (e2h_wr |-> ##2 e2h_irq && software_event_bits[0])
      else $error("ec-to-host write did not raise its source");

   a_h2e_pulse: assert property (h2e_wr |=> ec_h2e_irq)
      else $error("host-to-ec write gave no ec interrupt");

   a_dword_fetch: assert property (
      s_idle_data_rd ##0 (hb == 2'h0 && access_type[1] && cur_rd)
      |=> mem_out.req && !mem_out.we && mem_out.be == 4'hF)
      else $error("32-bit byte 0 read did not fetch a dword");

   a_half_commit: assert property (
      s_idle_data_wr ##0 (hb == 2'h3 && access_type == `HMWU_ACC_16 && cur_wr)
      |=> mem_out.req && mem_out.we && mem_out.be == 4'hC)
      else $error("16-bit byte 3 write did not commit upper half");

   a_ro_no_write: assert property (s_idle_data_wr ##0 !cur_wr |=> !mem_out.req)
      else $error("memory written outside a writable region");

   a_noacc_keep: assert property (
      s_idle_data_rd ##0 !cur_rd |=> !mem_out.req && $stable(window_data) && host_rvalid)
      else $error("no-access read touched memory or data");

   a_oob_inc: assert property (
      s_idle_data_rd ##0 (hb == 2'h3 && access_type == `HMWU_ACC_AUTO && !cur_rd)
      |=> window_dword == $past(window_dword) + 13'h0001)
      else $error("out-of-bounds byte 3 read did not advance");

   a_oob_hold: assert property (
      s_idle_data_wr ##0 (hb == 2'h3 && access_type == `HMWU_ACC_AUTO && !cur_wr)
      |=> $stable(window_dword))
      else $error("out-of-bounds byte 3 write advanced");

   a_aligned: assert property (mem_out.req |-> mem_out.addr[1:0] == 2'h0)
      else $error("memory access not dword aligned");
endmodule

// *** sim/hmwu_mem_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------
// far-side memory: word array, prompt or slowed acknowledge
// ----------------------------------------
module hmwu_mem_model (
   input wire logic clk_sys,
   input wire logic nrst,
   input wire logic slow,
   input wire hmwu_pkg::hmwu_mem_type mem_out,
   output logic mem_ack,
   output logic [31:0] mem_rdata
);
   logic [31:0] words [0:255];
   logic [31:0] last;
   logic [1:0] wait_cnt;
   // released data lines show the inverse of the last word, never a stale copy
   assign mem_rdata = mem_ack ? last : ~last;
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         mem_ack <= 1'b0;
         wait_cnt <= 2'h0;
         last <= 32'h0000_0000;
         for (int i = 0; i < 256; i++) words[i] <= 32'h0000_0000;
      end else if (mem_out.req && !mem_ack && wait_cnt == (slow ? 2'h2 : 2'h0)) begin
         mem_ack <= 1'b1;
         wait_cnt <= 2'h0;
         last <= words[mem_out.addr[9:2]];
         for (int b = 0; b < 4; b++) begin
            if (mem_out.we && mem_out.be[b]) begin
               words[mem_out.addr[9:2]][b*8 +: 8] <= mem_out.wdata[b*8 +: 8];
            end
         end
      end else begin
         mem_ack <= 1'b0;
         wait_cnt <= (mem_out.req && !mem_ack) ? wait_cnt + 2'h1 : 2'h0;
      end
   end
endmodule

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic wr;
      logic [3:0] a;
      logic [7:0] d;
   } hmwu_row_type;
   logic clk_sys = 1'b0;
   logic nrst = 1'b0;
   logic slow = 1'b0;
   hmwu_pkg::hmwu_host_req_type hq = '0;
   hmwu_pkg::hmwu_ec_req_type eq = '0;
   hmwu_pkg::hmwu_mem_type mem_out;
   logic [7:0] host_rdata, ec_rdata;
   logic host_rvalid, host_busy, ec_rvalid, mem_ack, host_event, e2h_irq, ec_h2e_irq;
   logic [31:0] mem_rdata;
   int failures = 0;
   int cmp_count = 0;
   int h2e_seen = 0;
   localparam hmwu_row_type rows [0:14] = '{
      '{1'b0, 4'hA, 8'h01}, '{1'b0, 4'hB, 8'h00}, '{1'b0, 4'h8, 8'h00}, '{1'b0, 4'h9, 8'h00},
      '{1'b0, 4'hC, 8'h00}, '{1'b0, 4'h1, 8'h00}, '{1'b0, 4'h0, 8'h00}, '{1'b1, 4'hC, 8'h5A},
      '{1'b0, 4'hC, 8'h5A}, '{1'b1, 4'h1, 8'hFF}, '{1'b0, 4'h1, 8'h00}, '{1'b1, 4'h2, 8'h5D},
      '{1'b0, 4'h2, 8'h5D}, '{1'b1, 4'h3, 8'h80}, '{1'b0, 4'h3, 8'h80}};
   // region 0: base 0x100, both limits 0x40; region 1: base 0x200, write-only 0x20
   localparam logic [7:0] cfg [0:15] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h40, 8'h00, 8'h40, 8'h00,
      8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h20, 8'h00};

   hmwu_top dut (.clk_sys(clk_sys), .nrst(nrst), .host_req(hq), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid), .host_busy(host_busy), .ec_req(eq), .ec_rdata(ec_rdata),
      .ec_rvalid(ec_rvalid), .mem_out(mem_out), .mem_ack(mem_ack), .mem_rdata(mem_rdata),
      .host_event(host_event), .e2h_irq(e2h_irq), .ec_h2e_irq(ec_h2e_irq));
   hmwu_mem_model u_mem (.clk_sys(clk_sys), .nrst(nrst), .slow(slow), .mem_out(mem_out),
      .mem_ack(mem_ack), .mem_rdata(mem_rdata));

   always #50 clk_sys = ~clk_sys;
   always @(posedge clk_sys) if (ec_h2e_irq === 1'b1) h2e_seen++;

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (failures == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic step;
      @(posedge clk_sys);
      #1;
   endtask
   // writes wait out host_busy, so the next request is never ignored
   task automatic hw(input logic [3:0] a, input logic [7:0] d);
      int n;
      hq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      step();
      hq.wr = 1'b0;
      step();
      for (n = 0; n < 20 && host_busy !== 1'b0; n++) step();
      if (n == 20) begin failures++; complete_run(); end
   endtask
   task automatic hr(input logic [3:0] a, input logic [7:0] exp);
      int n;
      hq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      step();
      hq.rd = 1'b0;
      for (n = 0; n < 20 && host_rvalid !== 1'b1; n++) step();
      if (n == 20) begin failures++; complete_run(); end
      check("host_rdata", {24'h00_0000, host_rdata}, {24'h00_0000, exp});
   endtask
   task automatic ew(input logic [4:0] a, input logic [7:0] d);
      eq = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      step();
      eq.wr = 1'b0;
      step();
   endtask
   task automatic er(input logic [4:0] a, input logic [7:0] exp);
      eq = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      step();
      check("ec_rdata", {23'h0, ec_rvalid, ec_rdata}, {23'h0, 1'b1, exp});
      eq.rd = 1'b0;
      step();
   endtask

   initial begin
      #2_000_000;
      failures++;
      complete_run();
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (4) step();
      check("reset_out", {host_busy, host_event, e2h_irq, ec_h2e_irq, mem_out.req}, 0);
      nrst = 1'b1;
      for (int i = 0; i < 15; i++) begin
         if (rows[i].wr) hw(rows[i].a, rows[i].d);
         else hr(rows[i].a, rows[i].d);
      end
      ew(5'h11, 8'hA5);
      repeat (3) step();
      check("e2h_event", {e2h_irq, host_event}, 2'h3);
      hr(4'h1, 8'hA5);
      hr(4'h8, 8'h01);
      hw(4'h8, 8'h01);
      repeat (2) step();
      check("event_clear", {e2h_irq, host_event}, 2'h0);
      hw(4'hA, 8'h02);
      ew(5'h12, 8'h02);
      repeat (3) step();
      check("sw_event", {e2h_irq, host_event}, 2'h1);
      hr(4'h8, 8'h02);
      hw(4'h8, 8'h02);
      ew(5'h11, 8'h5A);
      repeat (3) step();
      check("masked", {e2h_irq, host_event}, 2'h2);
      hw(4'h0, 8'h3C);
      er(5'h10, 8'h3C);
      check("h2e_pulses", h2e_seen, 1);
      for (int i = 0; i < 16; i++) ew(i[4:0], cfg[i]);
      er(5'h0E, 8'h20);
      // slowed memory first: the host must see busy stretch, not a lost request
      slow = 1'b1;
      hw(4'h2, 8'h02);
      hw(4'h3, 8'h00);
      for (int i = 0; i < 3; i++) hw(4'h4 + i[3:0], 8'h11 * (i[7:0] + 8'h01));
      check("no_commit", u_mem.words[8'h40], 32'h0000_0000);
      hw(4'h7, 8'h44);
      check("dword", u_mem.words[8'h40], 32'h4433_2211);
      hw(4'h4, 8'h00);
      hr(4'h4, 8'h11);
      hr(4'h5, 8'h22);
      slow = 1'b0;
      hw(4'h2, 8'h01);
      hw(4'h6, 8'h55);
      hw(4'h7, 8'h66);
      check("half", u_mem.words[8'h40], 32'h6655_2211);
      hw(4'h6, 8'h00);
      hr(4'h6, 8'h55);
      hw(4'h2, 8'h00);
      hw(4'h5, 8'h99);
      check("byte", u_mem.words[8'h40], 32'h6655_9911);
      hw(4'h2, 8'h03);
      hr(4'h7, 8'h66);
      hr(4'h2, 8'h07);
      hw(4'h2, 8'h02);
      hw(4'h3, 8'h80);
      for (int i = 0; i < 4; i++) hw(4'h4 + i[3:0], 8'hA1 + i[7:0]);
      check("write_only", u_mem.words[8'h80], 32'hA4A3_A2A1);
      hw(4'h4, 8'h00);
      hr(4'h4, 8'h00);
      hw(4'h2, 8'h22);
      hw(4'h7, 8'hEE);
      check("past_limit", u_mem.words[8'h88], 32'h0000_0000);
      hw(4'h2, 8'h23);
      hw(4'h7, 8'hEF);
      hr(4'h2, 8'h23);
      hr(4'h7, 8'hEF);
      hr(4'h2, 8'h27);
      nrst = 1'b0;
      step();
      check("reset_mid", {host_busy, host_event, e2h_irq, mem_out.req}, 4'h0);
      nrst = 1'b1;
      hr(4'hC, 8'h00);
      hr(4'h1, 8'h00);
      complete_run();
   end
endmodule
